// File: slot_hub_chk_props.sv
`timescale 1ns/10ps
module slot_hub_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic event_i,
	input wire logic [9:0] event_target_o,
	input wire logic event_route_o,
	input wire logic [5:0] think_gap_o
);
	logic [31:0] ctx_reg, ctx_next, info_reg, info_next;
	logic [11:0] ar_reg, ar_next;
	logic wr;
	logic [5:0] gap;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign gap = info_reg[4] && info_reg[3:0] == 4'h3 ? ({4'h0, ctx_reg[17:16]} + 6'h01) << 3 : 6'h00;
	// mirror of what software wrote
	always_comb
	begin
		ctx_next = wr && s_axi_awaddr == 12'h000 ? s_axi_wdata : ctx_reg;
		info_next = wr && s_axi_awaddr == 12'h004 ? s_axi_wdata : info_reg;
		ar_next = s_axi_arvalid ? s_axi_araddr : ar_reg;
	end
	always_ff @(posedge clk_i)
	begin
		ctx_reg <= nrst_i ? ctx_next : 32'h0;
		info_reg <= nrst_i ? info_next : 32'h0;
		ar_reg <= ar_next;
	end
	sequence s_settled;
		($stable(ctx_reg) && $stable(info_reg)) [*4];
	endsequence
	sequence s_rd(logic [11:0] a);
		s_axi_rvalid && s_axi_rready && ar_reg == a;
	endsequence
	property p_route;
		event_i |=> event_route_o && event_target_o == ctx_reg[31:22];
	endproperty
	a_route: assert property (p_route) else $error("event not routed");
	property p_hold;
		!event_i |=> !event_route_o && $stable(event_target_o);
	endproperty
	a_hold: assert property (p_hold) else $error("target moved");
	property p_gap;
		s_settled |-> think_gap_o == gap;
	endproperty
	a_gap: assert property (p_gap) else $error("gap wrong");
	property p_step;
		think_gap_o[2:0] == 3'h0 && think_gap_o <= 6'h20;
	endproperty
	a_step: assert property (p_step) else $error("gap not a step");
	property p_wb;
		s_settled ##0 s_rd(12'h014) |-> s_axi_rdata == (ctx_reg & 32'hFFC3FFFF);
	endproperty
	a_wb: assert property (p_wb) else $error("reserved not zero");
	property p_raw;
		s_settled ##0 s_rd(12'h000) |-> s_axi_rdata == ctx_reg;
	endproperty
	a_raw: assert property (p_raw) else $error("fields moved");
	property p_zero;
		s_settled ##0 s_rd(12'h010) |-> s_axi_rdata[4] == ((info_reg[5] || info_reg[6]
			|| info_reg[3:0] == 4'h3) && ctx_reg[15:0] != 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero check wrong");
	property p_unmapped;
		s_rd(12'h040) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind slot_hub_fields slot_hub_chk i_chk (.*);

// File: slot_hub_defines.svh
`ifndef SLOT_HUB_DEFINES_SVH
`define SLOT_HUB_DEFINES_SVH

// register byte offsets
`define OFF_CTX_WORD 12'h000
`define OFF_CTX_INFO 12'h004
`define OFF_CTRL 12'h008
`define OFF_DECODE 12'h00C
`define OFF_CHECK 12'h010
`define OFF_WRITEBACK 12'h014
`define OFF_EVENT 12'h018
`define OFF_ROUTE 12'h01C

// context word field positions
`define HUB_SLOT_MSB 7
`define HUB_SLOT_LSB 0
`define HUB_PORT_MSB 15
`define HUB_PORT_LSB 8
`define THINK_MSB 17
`define THINK_LSB 16
`define RSVD_MSB 21
`define RSVD_LSB 18
`define INTR_MSB 31
`define INTR_LSB 22

// info register layout: speed, hub flag, root attach, top rank, higher-rank parent
`define INFO_SPEED_MSB 3
`define INFO_SPEED_LSB 0
`define INFO_HUB_BIT 4
`define INFO_ROOT_BIT 5
`define INFO_TOPRANK_BIT 6
`define INFO_HIRANK_BIT 7

// speed codes
`define SPEED_FS 4'h1
`define SPEED_LS 4'h2
`define SPEED_HS 4'h3

// think time: fs bit times per code step
`define THINK_STEP_BITS 6'h08
`define INTR_COUNT_RESET 10'h008

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: slot_hub_fields.sv
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "slot_hub_defines.svh"
module slot_hub_fields (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic event_i,
	output logic [9:0] event_target_o,
	output logic event_route_o,
	output logic [5:0] think_gap_o
);
	import slot_hub_pkg::*;

	wr_state_type wr_state_reg, wr_state_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [11:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next, bvalid_reg, bvalid_next;
	word_type ctx_reg, ctx_next;
	logic [7:0] info_reg, info_next;
	logic [9:0] intr_count_reg, intr_count_next;
	logic [9:0] target_reg, target_next;
	logic route_reg, route_next;
	logic [5:0] gap_reg, gap_next;
	logic [31:0] errs_reg, errs_next;
	logic [5:0] gap_dec;
	logic [31:0] wb_word;
	logic [31:0] chk;
	logic [31:0] wr_merged, wr_cur;
	logic [31:0] rd_val;
	logic rd_ok;
	logic is_lsfs, is_hs, is_hs_hub, behind_tt, behind_rank, zero_case;
	logic [7:0] f_slot, f_port;
	logic [1:0] f_think;
	logic [9:0] f_intr;

	think_time_decode u_think (
		.code_i(f_think),
		.gap_bits_o(gap_dec)
	);

	// field decode
	always_comb
	begin
		f_slot = ctx_reg[`HUB_SLOT_MSB:`HUB_SLOT_LSB];
		f_port = ctx_reg[`HUB_PORT_MSB:`HUB_PORT_LSB];
		f_think = ctx_reg[`THINK_MSB:`THINK_LSB];
		f_intr = ctx_reg[`INTR_MSB:`INTR_LSB];
		is_lsfs = (info_reg[`INFO_SPEED_MSB:`INFO_SPEED_LSB] == `SPEED_FS)
			|| (info_reg[`INFO_SPEED_MSB:`INFO_SPEED_LSB] == `SPEED_LS);
		is_hs = info_reg[`INFO_SPEED_MSB:`INFO_SPEED_LSB] == `SPEED_HS;
		is_hs_hub = is_hs && info_reg[`INFO_HUB_BIT];
		zero_case = info_reg[`INFO_ROOT_BIT] || is_hs || info_reg[`INFO_TOPRANK_BIT];
		behind_tt = is_lsfs && !zero_case;
		behind_rank = !is_lsfs && !zero_case && info_reg[`INFO_HIRANK_BIT];
		chk = 32'h0000_0000;
		chk[0] = behind_tt && (f_slot == 8'h00);
		chk[1] = behind_rank && (f_slot == 8'h00);
		chk[2] = behind_tt && (f_port == 8'h00);
		chk[3] = behind_rank && (f_port == 8'h00);
		chk[4] = zero_case && ((f_slot != 8'h00) || (f_port != 8'h00));
		chk[5] = !is_hs_hub && (f_think != 2'h0);
		chk[6] = f_intr >= intr_count_reg;
		// clean copy for writeback, reserved bits zero
		wb_word = ctx_reg;
		wb_word[`RSVD_MSB:`RSVD_LSB] = 4'h0;
	end

	// write-strobe merge
	always_comb
	begin
		wr_merged = 32'h0000_0000;
		wr_cur = rd_sel(aw_addr_reg);
		for (int i = 0; i < 4; i++)
		begin
			wr_merged[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : wr_cur[i*8 +: 8];
		end
	end

	function automatic logic [31:0] rd_sel(input logic [11:0] a);
		unique case (a)
			`OFF_CTX_WORD: rd_sel = ctx_reg;
			`OFF_CTX_INFO: rd_sel = {24'h000000, info_reg};
			`OFF_CTRL: rd_sel = {22'h000000, intr_count_reg};
			`OFF_DECODE: rd_sel = {8'h00, gap_reg, f_think, f_port, f_slot};
			`OFF_CHECK: rd_sel = errs_reg;
			`OFF_WRITEBACK: rd_sel = wb_word;
			`OFF_EVENT: rd_sel = {21'h000000, route_reg, target_reg};
			`OFF_ROUTE: rd_sel = {22'h000000, f_intr};
			default: rd_sel = 32'h0000_0000;
		endcase
	endfunction

	always_comb
	begin
		rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `OFF_ROUTE);
		rd_val = rd_sel(s_axi_araddr);
	end

	// bus and state next values
	always_comb
	begin
		wr_state_next = wr_state_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		ctx_next = ctx_reg;
		info_next = info_reg;
		intr_count_next = intr_count_reg;
		target_next = target_reg;
		route_next = 1'b0;
		gap_next = is_hs_hub ? gap_dec : 6'h00;
		errs_next = chk;
		unique case (wr_state_reg)
			wr_idle_type_s:
			begin
				if (s_axi_awvalid && !aw_have_reg)
				begin
					aw_have_next = 1'b1;
					aw_addr_next = s_axi_awaddr;
				end
				if (s_axi_wvalid && !w_have_reg)
				begin
					w_have_next = 1'b1;
					w_data_next = s_axi_wdata;
					w_strb_next = s_axi_wstrb;
				end
				if (aw_have_reg && w_have_reg)
				begin
					aw_have_next = 1'b0;
					w_have_next = 1'b0;
					bresp_next = `RESP_OKAY;
					wr_state_next = wr_resp_type_s;
					unique case (aw_addr_reg)
						`OFF_CTX_WORD: ctx_next = wr_merged;
						`OFF_CTX_INFO: info_next = wr_merged[7:0];
						`OFF_CTRL: intr_count_next = wr_merged[9:0];
						default: bresp_next = `RESP_SLVERR;
					endcase
				end
			end
			wr_resp_type_s:
			begin
				if (s_axi_bready)
				begin
					wr_state_next = wr_idle_type_s;
				end
			end
		endcase
		if (rvalid_reg)
		begin
			if (s_axi_rready)
			begin
				rvalid_next = 1'b0;
			end
		end
		else if (s_axi_arvalid && arready_reg)
		begin
			rvalid_next = 1'b1;
			rdata_next = rd_ok ? rd_val : 32'h0000_0000;
			rresp_next = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		// slot events go to the programmed interrupter
		if (event_i)
		begin
			target_next = f_intr;
			route_next = 1'b1;
		end
		// each ready is a one-cycle pulse after valid is seen
		awready_next = (wr_state_reg == wr_idle_type_s) && s_axi_awvalid && !aw_have_reg && !awready_reg;
		wready_next = (wr_state_reg == wr_idle_type_s) && s_axi_wvalid && !w_have_reg && !wready_reg;
		arready_next = !rvalid_reg && s_axi_arvalid && !arready_reg;
		bvalid_next = wr_state_next == wr_resp_type_s;
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			wr_state_reg <= wr_idle_type_s;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bresp_reg <= `RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
			ctx_reg <= 32'h0000_0000;
			info_reg <= 8'h00;
			intr_count_reg <= `INTR_COUNT_RESET;
			target_reg <= 10'h000;
			route_reg <= 1'b0;
			gap_reg <= 6'h00;
			errs_reg <= 32'h0000_0000;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
		end
		else
		begin
			wr_state_reg <= wr_state_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			ctx_reg <= ctx_next;
			info_reg <= info_next;
			intr_count_reg <= intr_count_next;
			target_reg <= target_next;
			route_reg <= route_next;
			gap_reg <= gap_next;
			errs_reg <= errs_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			bvalid_reg <= bvalid_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign event_target_o = target_reg;
	assign event_route_o = route_reg;
	assign think_gap_o = gap_reg;
endmodule

// File: slot_hub_pkg.sv
package slot_hub_pkg;
	typedef enum logic [1:0] {
		wr_idle_type_s,
		wr_resp_type_s
	} wr_state_type;
	typedef logic [31:0] word_type;
endpackage

// File: soft_model.sv
`timescale 1ns/10ps
module soft_model (
	input wire logic clk_i,
	output logic [11:0] s_axi_awaddr = 12'h000,
	output logic s_axi_awvalid = 1'b0,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic [3:0] s_axi_wstrb = 4'hF,
	output logic s_axi_wvalid = 1'b0,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready = 1'b0,
	output logic [11:0] s_axi_araddr = 12'h000,
	output logic s_axi_arvalid = 1'b0,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready = 1'b0
);
	function automatic logic [31:0] ctx(logic [15:0] sp, logic [1:0] t, logic [9:0] n, logic hh);
		return {n < 10'h008 ? n : 10'h000, 4'h0, hh ? t : 2'h0, sp};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ad, dd;
		@(posedge clk_i);
		{ad, dd} = 2'h0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!(ad && dd))
		begin
			@(posedge clk_i);
			if (s_axi_arready)
				ad = 1'b1;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !dd)
			begin
				{dd, d, r} = {1'b1, s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
			end
		end
	endtask
endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk_i, nrst_i, event_i, event_route_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [9:0] event_target_o;
	logic [5:0] think_gap_o;
	int error_cnt, checked;
	slot_hub_fields i_dut (.*);
	soft_model i_sw (.*);
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task stop_test;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task w(input logic [11:0] a, input logic [31:0] d);
		i_sw.wr(a, d, rs);
		repeat (4) @(posedge clk_i);
	endtask
	task t_think;
		i_sw.rd(12'h008, rv, rs);
		cmp("count", 32'h8, rv);
		for (int c = 0; c < 4; c++)
		begin
			w(12'h004, 32'h13);
			w(12'h000, i_sw.ctx(16'h0, c[1:0], 10'h0, 1'b1));
			cmp("gap", 8 * c + 8, think_gap_o);
		end
		w(12'h004, 32'h1);
		cmp("gap", 32'h0, think_gap_o);
		$display("t_think end");
	endtask
	task t_rsvd;
		w(12'h000, 32'hFFFFFFFF);
		i_sw.rd(12'h014, rv, rs);
		cmp("wback", 32'hFFC3FFFF, rv);
		i_sw.rd(12'h000, rv, rs);
		cmp("ctx", 32'hFFFFFFFF, rv);
		$display("t_rsvd end");
	endtask
	task t_event;
		w(12'h000, i_sw.ctx(16'h0, 2'h0, 10'h7, 1'b0));
		event_i <= 1'b1;
		@(posedge clk_i);
		event_i <= 1'b0;
		#1;
		cmp("route", 32'h1, event_route_o);
		cmp("target", 32'h7, event_target_o);
		@(posedge clk_i);
		#1;
		cmp("route", 32'h0, event_route_o);
		$display("t_event end");
	endtask
	task t_zero;
		w(12'h004, 32'h21);
		w(12'h000, 32'h5);
		i_sw.rd(12'h010, rv, rs);
		cmp("root", 32'h1, rv[4]);
		w(12'h004, 32'h3);
		i_sw.rd(12'h010, rv, rs);
		cmp("hs", 32'h1, rv[4]);
		w(12'h000, 32'h0);
		i_sw.rd(12'h010, rv, rs);
		cmp("clear", 32'h0, rv[4]);
		w(12'h004, 32'h1);
		i_sw.rd(12'h010, rv, rs);
		cmp("tt unset", 32'h5, rv);
		w(12'h000, 32'h0305);
		i_sw.rd(12'h010, rv, rs);
		cmp("tt set", 32'h0, rv);
		w(12'h004, 32'h84);
		i_sw.rd(12'h010, rv, rs);
		cmp("rank set", 32'h0, rv);
		w(12'h000, 32'h0);
		i_sw.rd(12'h010, rv, rs);
		cmp("rank unset", 32'hA, rv);
		w(12'h000, 32'h0240_0000);
		i_sw.rd(12'h010, rv, rs);
		cmp("intr range", 32'h4A, rv);
		$display("t_zero end");
	endtask
	task t_err;
		i_sw.wr(12'h00C, 32'h0, rs);
		cmp("bresp", 32'h2, rs);
		i_sw.rd(12'h040, rv, rs);
		cmp("rresp", 32'h2, rs);
		cmp("rdata", 32'h0, rv);
		$display("t_err end");
	endtask
	initial
	begin
		nrst_i = 1'b0;
		event_i = 1'b0;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_think;
		t_rsvd;
		t_event;
		t_zero;
		t_err;
		stop_test;
	end
	initial
	begin
		#40000;
		error_cnt++;
		stop_test;
	end
endmodule

// File: think_time_decode.sv
`timescale 1ns/10ps
`include "slot_hub_defines.svh"
module think_time_decode (
	input wire logic [1:0] code_i,
	output logic [5:0] gap_bits_o
);
	// code n gives (n+1) x 8 fs bit times
	always_comb
	begin
		gap_bits_o = 6'({4'h0, code_i} + 6'h01) * `THINK_STEP_BITS;
	end
endmodule
